// [rtl/acs_regs.vh]
// register layout, field positions and timing counts of the channel sequencer
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
// control word field positions on the write data bus
`define ACS_CTL_SEQ_BIT 1
`define ACS_CTL_MASK_TARGET_SELECT_BIT_BIT 2
`define ACS_CTL_CODING_BIT 3
`define ACS_CTL_PM_LO_BIT 4
`define ACS_CTL_PM_HI_BIT 5
`define ACS_CTL_MODE_LO_BIT 6
`define ACS_CTL_MODE_HI_BIT 7
`define ACS_CTL_ADDR_LO_BIT 8
`define ACS_CTL_ADDR_HI_BIT 10
`define ACS_CTL_RANGE_BIT 0
// reset values
`define ACS_CTL_RESET 12'h000
`define ACS_MASK_RESET 8'h00
// conversion length in conversion-clock periods
`define ACS_CONV_PERIODS 4'hD
// result width
`define ACS_RESULT_BITS 12
// sequencer modes {seq, mask_target_select_bit}
`define ACS_SQ_OFF 2'h0
`define ACS_SQ_LOAD 2'h1
`define ACS_SQ_KEEP 2'h2
`define ACS_SQ_CONSEC 2'h3
`endif

// [rtl/acs_sequencer.v]
// channel sequencer and conversion control of the eight-input converter
// ---------------------------------------------------------------
// Overview of operation
// R1: conversion finishes only after thirteen full clock periods
// R2: host re-edges start or clock after abort
// R3: write-only eight-bit mask, captured at strobe rise
// R4: mask write only after seq 0, shadow 1
// R5: mask bit n selects input n
// R6: host sets both bits of each pair
// R7: start edges step ascending, wrap to lowest
// R8: sequencing holds until control word not 1,0
// R9: never convert swapped-polarity pair in pair modes; code masks odd channels only in sequencing, not direct address
// R10: mode 0,0 uses written channel address
// R11: mode 0,1 loads mask, then cycles it
// R12: mode 1,0 updates fields, sequence keeps going
// R13: mode 1,1 cycles channel zero to address
// R14: coding bit picks straight binary or two's complement
// R15: twelve-bit code, one step per lsb
// R16: config 0,0 single-ended, 0,1 differential pairs
// R17: reset leaves sequencer idle, no mask
// ---------------------------------------------------------------
`include "acs_regs.vh"
module acs_sequencer #(
   parameter CH_BITS = 3,
   parameter RES_BITS = `ACS_RESULT_BITS
) (
   input wire clk,
   input wire rst_b,
   input wire clk_en,
   input wire wr_b,
   input wire [11:0] data_bus,
   input wire conversion_start_n,
   input wire conversion_clock_in,
   input wire [RES_BITS-1:0] sar_result,
   output reg [CH_BITS-1:0] pos_channel_ff,
   output reg [CH_BITS-1:0] neg_channel_ff,
   output reg neg_is_ground_ff,
   output reg converting_ff,
   output reg conv_done_ff,
   output reg conv_abort_ff,
   output reg [RES_BITS-1:0] result_ff,
   output reg range_ff,
   output reg [1:0] power_select_ff,
   output reg [1:0] input_config_ff
);
   localparam NCH = 1 << CH_BITS;
   // ---------------------------------------------------------------
   // edge detection
   // ---------------------------------------------------------------
   reg wr_b_q_ff;
   reg start_q_ff;
   reg cclk_q_ff;
   wire wr_rise = wr_b & ~wr_b_q_ff;
   wire start_fall = ~conversion_start_n & start_q_ff;
   wire cclk_fall = ~conversion_clock_in & cclk_q_ff;
   // ---------------------------------------------------------------
   // control and mask registers
   // ---------------------------------------------------------------
   reg [11:0] ctl_ff;
   reg [NCH-1:0] mask_ff;
   reg mask_next_ff;
   reg seq_run_ff;
   reg [CH_BITS-1:0] cur_ff;
   wire [1:0] wmode = {data_bus[`ACS_CTL_SEQ_BIT], data_bus[`ACS_CTL_MASK_TARGET_SELECT_BIT_BIT]};
   wire [1:0] mode_cfg = {ctl_ff[`ACS_CTL_MODE_HI_BIT], ctl_ff[`ACS_CTL_MODE_LO_BIT]};
   wire pair_mode = (mode_cfg == 2'h1) | (mode_cfg == 2'h2);
   wire [CH_BITS-1:0] addr = ctl_ff[`ACS_CTL_ADDR_HI_BIT:`ACS_CTL_ADDR_LO_BIT];
   // ---------------------------------------------------------------
   // next selected channel after cur, ascending with wrap
   // ---------------------------------------------------------------
   reg [NCH-1:0] eff_mask;
   reg [CH_BITS-1:0] nxt_ch;
   reg found;
   reg [CH_BITS-1:0] probe;
   integer i;
   always @* begin
      eff_mask = mask_ff; // R5
      if (pair_mode) begin
         for (i = 1; i < NCH; i = i + 2) begin
            eff_mask[i] = 1'b0; // R9
         end
      end
      nxt_ch = cur_ff;
      found = 1'b0;
      probe = cur_ff;
      for (i = 1; i <= NCH; i = i + 1) begin
         probe = cur_ff + i[CH_BITS-1:0]; // R7
         if (!found && eff_mask[probe]) begin
            nxt_ch = probe;
            found = 1'b1;
         end
      end
   end
   // ---------------------------------------------------------------
   // write handling and sequence stepping
   // ---------------------------------------------------------------
   // ---------------------------------------------------------------
   // input edge history, reset to the idle levels of the pins
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_b_q_ff <= 1'b1;
         start_q_ff <= 1'b1;
         cclk_q_ff <= 1'b1;
      end else if (clk_en) begin
         wr_b_q_ff <= wr_b;
         start_q_ff <= conversion_start_n;
         cclk_q_ff <= conversion_clock_in;
      end
   end
   // ---------------------------------------------------------------
   // control word, sequence mask and sequence position
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl_ff <= `ACS_CTL_RESET; // R17
         mask_ff <= `ACS_MASK_RESET; // R17
         mask_next_ff <= 1'b0;
         seq_run_ff <= 1'b0;
         cur_ff <= {CH_BITS{1'b1}};
      end else if (clk_en) begin
         if (wr_rise) begin
            if (mask_next_ff) begin
               mask_ff <= data_bus[NCH-1:0]; // R3 R11
               mask_next_ff <= 1'b0;
               seq_run_ff <= 1'b1;
               cur_ff <= {CH_BITS{1'b1}};
            end else begin
               ctl_ff <= data_bus; // R4
               mask_next_ff <= (wmode == `ACS_SQ_LOAD); // R4
               case (wmode)
                  `ACS_SQ_KEEP: begin
                  end // R12
                  `ACS_SQ_CONSEC: begin
                     mask_ff <= {NCH{1'b1}} >> ((NCH - 1) - data_bus[`ACS_CTL_ADDR_HI_BIT:`ACS_CTL_ADDR_LO_BIT]); // R13
                     seq_run_ff <= 1'b1;
                     cur_ff <= {CH_BITS{1'b1}};
                  end
                  default: begin
                     seq_run_ff <= 1'b0; // R8 R10
                  end
               endcase
            end
         end
         if (start_fall && seq_run_ff) begin
            cur_ff <= nxt_ch; // R7
         end
      end
   end
   // ---------------------------------------------------------------
   // output coding of the raw converter code
   // ---------------------------------------------------------------
   wire [RES_BITS-1:0] coded_result = ctl_ff[`ACS_CTL_CODING_BIT] ?
      {~sar_result[RES_BITS-1], sar_result[RES_BITS-2:0]} : sar_result; // R14 R15
   // ---------------------------------------------------------------
   // conversion period count, completion and abort
   // ---------------------------------------------------------------
   reg [3:0] per_cnt_ff;
   wire last_period = (per_cnt_ff == `ACS_CONV_PERIODS - 4'h1);
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         per_cnt_ff <= 4'h0;
         converting_ff <= 1'b0;
         conv_done_ff <= 1'b0;
         conv_abort_ff <= 1'b0;
         result_ff <= {RES_BITS{1'b0}};
      end else if (clk_en) begin
         conv_done_ff <= 1'b0;
         conv_abort_ff <= 1'b0;
         if (start_fall) begin
            converting_ff <= 1'b1;
            per_cnt_ff <= 4'h0;
            conv_abort_ff <= converting_ff; // R1
         end else if (converting_ff) begin
            if (cclk_fall) begin
               if (last_period) begin
                  converting_ff <= 1'b0; // R1
                  conv_done_ff <= 1'b1;
                  result_ff <= coded_result; // R14 R15
               end
               per_cnt_ff <= per_cnt_ff + 4'h1;
            end
            if (wr_rise && !last_period) begin
               converting_ff <= 1'b0; // R1 R2
               conv_abort_ff <= 1'b1;
            end
         end
      end
   end
   // ---------------------------------------------------------------
   // input selection of each conversion
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pos_channel_ff <= {CH_BITS{1'b0}};
         neg_channel_ff <= {CH_BITS{1'b0}};
         neg_is_ground_ff <= 1'b1;
      end else if (clk_en) begin
         if (start_fall) begin
            if (seq_run_ff) begin
               pos_channel_ff <= nxt_ch; // R7
               neg_channel_ff <= nxt_ch ^ {{(CH_BITS-1){1'b0}}, 1'b1};
            end else begin
               pos_channel_ff <= addr; // R10
               neg_channel_ff <= addr ^ {{(CH_BITS-1){1'b0}}, 1'b1};
            end
            if (mode_cfg == 2'h3) begin
               neg_channel_ff <= {CH_BITS{1'b1}};
            end
            neg_is_ground_ff <= (mode_cfg == 2'h0); // R16
         end
      end
   end
   // ---------------------------------------------------------------
   // registered copies of the control fields
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         range_ff <= 1'b0;
         power_select_ff <= 2'h0;
         input_config_ff <= 2'h0;
      end else if (clk_en) begin
         range_ff <= ctl_ff[`ACS_CTL_RANGE_BIT];
         power_select_ff <= {ctl_ff[`ACS_CTL_PM_HI_BIT], ctl_ff[`ACS_CTL_PM_LO_BIT]};
         input_config_ff <= mode_cfg;
      end
   end
endmodule

// [tb/acs_sequencer_monitor.sv]
// assertion checker on the sequencer ports
module acs_mon #(
   parameter RES_BITS = 12
) (
   input wire clk,
   input wire rst_b,
   input wire clk_en,
   input wire conversion_start_n,
   input wire conversion_clock_in,
   input wire [RES_BITS-1:0] sar_result,
   input wire [RES_BITS-1:0] result_ff,
   input wire converting_ff,
   input wire conv_done_ff,
   input wire conv_abort_ff,
   input wire neg_is_ground_ff,
   input wire [1:0] input_config_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   reg clk_in_d_ff;
   reg [4:0] fall_cnt_ff;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // ---
   // conversion-clock falls since start
   // ---
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_in_d_ff <= 1'b1;
         fall_cnt_ff <= 5'h00;
      end else begin
         clk_in_d_ff <= conversion_clock_in;
         if (!conversion_start_n) fall_cnt_ff <= 5'h00;
         else if (clk_in_d_ff && !conversion_clock_in) fall_cnt_ff <= fall_cnt_ff + 5'h01;
      end
   end
   a_done_pulse: assert property (conv_done_ff |=> !conv_done_ff)
      else $error("done too long");
   a_done_count: assert property (conv_done_ff |-> fall_cnt_ff == 5'h0D)
      else $error("done at wrong count");
   a_done_ends: assert property (conv_done_ff |-> !converting_ff && $past(converting_ff))
      else $error("done without conversion");
   a_end_cause: assert property ($fell(converting_ff) |-> conv_done_ff || conv_abort_ff)
      else $error("conversion dropped");
   a_start_conv: assert property ($fell(conversion_start_n) && clk_en && !converting_ff |=> converting_ff)
      else $error("start ignored");
   a_result_code: assert property (conv_done_ff |-> result_ff[10:0] == $past(sar_result[10:0]))
      else $error("result low bits");
   a_ground_single: assert property (input_config_ff == 2'h0 |-> neg_is_ground_ff)
      else $error("negative not ground");
   a_idle_quiet: assert property (!converting_ff && !$past(converting_ff) |-> !conv_done_ff)
      else $error("done while idle");
   a_abort_pulse: assert property (conv_abort_ff |=> !conv_abort_ff)
      else $error("abort too long");
   a_abort_nodone: assert property (conv_abort_ff |-> !conv_done_ff)
      else $error("abort with done");
endmodule

// [tb/acs_host_model.sv]
// host and converter-core model
module acs_host (
   input wire clk,
   output logic wr_b = 1'b1,
   output logic [11:0] data_bus = 12'h000,
   output logic conversion_start_n = 1'b1,
   output logic conversion_clock_in = 1'b1,
   output logic [11:0] sar_result = 12'h000
);
   timeunit 1ns;
   timeprecision 1ps;
   task wr(input logic [11:0] d);
      @(posedge clk);
      wr_b <= 1'b0;
      data_bus <= d;
      @(posedge clk);
      wr_b <= 1'b1;
      repeat (2) @(posedge clk);
      data_bus <= ~d;
      repeat (2) @(posedge clk);
   endtask
   task conv(input logic [11:0] r, input int n);
      @(posedge clk);
      conversion_start_n <= 1'b0;
      sar_result <= r;
      repeat (2) @(posedge clk);
      conversion_start_n <= 1'b1;
      repeat (n) begin
         conversion_clock_in <= 1'b0;
         repeat (2) @(posedge clk);
         conversion_clock_in <= 1'b1;
         repeat (2) @(posedge clk);
      end
      sar_result <= ~r;
   endtask
endmodule

// [tb/acs_sequencer_tb_top.sv]
// testbench top of the channel sequencer
bind acs_sequencer acs_mon #(.RES_BITS(RES_BITS)) i_mon (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
   .conversion_start_n(conversion_start_n), .conversion_clock_in(conversion_clock_in), .sar_result(sar_result),
   .result_ff(result_ff), .converting_ff(converting_ff), .conv_done_ff(conv_done_ff),
   .conv_abort_ff(conv_abort_ff), .neg_is_ground_ff(neg_is_ground_ff), .input_config_ff(input_config_ff));
module acs_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   wire wr_b, conversion_start_n, conversion_clock_in, neg_is_ground_ff, converting_ff, conv_done_ff, conv_abort_ff;
   wire range_ff;
   wire [11:0] data_bus, sar_result, result_ff;
   wire [2:0] pos_channel_ff, neg_channel_ff;
   wire [1:0] power_select_ff, input_config_ff;
   int num_errors = 0, n_checks = 0, ndone = 0, nabort = 0;
   logic [11:0] got_ch, got_res;
   always #25 clk = ~clk;
   always @(posedge clk) if (conv_done_ff === 1'b1) begin
      ndone <= ndone + 1;
      got_ch <= {9'h000, pos_channel_ff};
      got_res <= result_ff;
   end
   always @(posedge clk) if (conv_abort_ff === 1'b1) nabort <= nabort + 1;
   acs_host i_host (.clk(clk), .wr_b(wr_b), .data_bus(data_bus), .conversion_start_n(conversion_start_n),
      .conversion_clock_in(conversion_clock_in), .sar_result(sar_result));
   acs_sequencer i_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .wr_b(wr_b), .data_bus(data_bus),
      .conversion_start_n(conversion_start_n), .conversion_clock_in(conversion_clock_in), .sar_result(sar_result),
      .pos_channel_ff(pos_channel_ff), .neg_channel_ff(neg_channel_ff), .neg_is_ground_ff(neg_is_ground_ff),
      .converting_ff(converting_ff), .conv_done_ff(conv_done_ff), .conv_abort_ff(conv_abort_ff),
      .result_ff(result_ff), .range_ff(range_ff), .power_select_ff(power_select_ff),
      .input_config_ff(input_config_ff));
   task give_verdict;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [11:0] g, input logic [11:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task run(input logic [11:0] r, input logic [2:0] ch, input logic [11:0] e);
      int n0;
      n0 = ndone;
      i_host.conv(r, 13);
      for (int i = 0; i < 20 && ndone == n0; i++) @(negedge clk);
      if (ndone == n0) begin
         num_errors++;
         $display("[ERR] %0t no completion", $time);
         give_verdict;
      end else begin
         chk(got_ch, {9'h000, ch});
         chk(got_res, e);
      end
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      chk({10'h000, neg_is_ground_ff, converting_ff}, 12'h002);
      i_host.wr(12'h501);
      chk({11'h000, range_ff}, 12'h001);
      run(12'h123, 3'h5, 12'h123);
      $display("test direct done");
      i_host.wr(12'h004);
      i_host.wr(12'h0A5);
      chk({11'h000, range_ff}, 12'h000);
      run(12'h0F0, 3'h0, 12'h0F0);
      run(12'h0F1, 3'h2, 12'h0F1);
      run(12'h0F2, 3'h5, 12'h0F2);
      run(12'h0F3, 3'h7, 12'h0F3);
      run(12'h0F4, 3'h0, 12'h0F4);
      i_host.wr(12'h00A);
      run(12'h123, 3'h2, 12'h923);
      $display("test mask done");
      i_host.wr(12'h206);
      run(12'h7FF, 3'h0, 12'h7FF);
      run(12'h800, 3'h1, 12'h800);
      run(12'hFFF, 3'h2, 12'hFFF);
      run(12'h001, 3'h0, 12'h001);
      $display("test consecutive done");
      i_host.conv(12'h000, 5);
      i_host.wr(12'h300);
      chk(nabort[11:0], 12'h001);
      run(12'h456, 3'h3, 12'h456);
      $display("test stop done");
      i_host.wr(12'h4F0);
      chk({10'h000, power_select_ff}, 12'h003);
      chk({10'h000, input_config_ff}, 12'h003);
      run(12'h321, 3'h4, 12'h321);
      chk({9'h000, neg_channel_ff}, 12'h007);
      chk({11'h000, neg_is_ground_ff}, 12'h000);
      clk_en <= 1'b0;
      i_host.wr(12'h000);
      clk_en <= 1'b1;
      run(12'h654, 3'h4, 12'h654);
      chk({10'h000, power_select_ff}, 12'h003);
      i_host.wr(12'h541);
      run(12'h0AB, 3'h5, 12'h0AB);
      chk({9'h000, neg_channel_ff}, 12'h004);
      $display("test config done");
      i_host.wr(12'h084);
      chk({10'h000, input_config_ff}, 12'h002);
      i_host.wr(12'h03C);
      run(12'h010, 3'h2, 12'h010);
      chk({9'h000, neg_channel_ff}, 12'h003);
      i_host.conv(12'h000, 5);
      run(12'h020, 3'h2, 12'h020);
      chk(nabort[11:0], 12'h002);
      run(12'h030, 3'h4, 12'h030);
      chk({9'h000, neg_channel_ff}, 12'h005);
      $display("test pairs done");
      give_verdict;
   end
endmodule
